// file: rtl/adc_seq_pkg.sv
package adc_seq_pkg;

    // Register byte offsets on the APB
    localparam logic [7:0] OFS_SCR = 8'h00;
    localparam logic [7:0] OFS_RES_HIGH = 8'h04;
    localparam logic [7:0] OFS_RES_LOW = 8'h08;
    localparam logic [7:0] OFS_CLK = 8'h0C;

    localparam logic [4:0] CH_ALL_ONES = 5'h1F;
    localparam logic [7:0] CLK_WR_MASK = 8'h7B;
    localparam logic [9:0] RES_RESET = 10'h000;
    localparam int RAW_W = 11;

    // Timing in converter clocks unless named otherwise
    localparam int SYNC_BUS_CLKS = 3;
    localparam int FIRST_EXTRA_CONVERTER_CLOCK = 2;
    localparam int CONV_CONVERTER_CLOCK_8_SHORT = 16;
    localparam int CONV_CONVERTER_CLOCK_8_LONG = 36;
    localparam int CONV_CONVERTER_CLOCK_10_SHORT = 19;
    localparam int CONV_CONVERTER_CLOCK_10_LONG = 39;
    localparam int SAMPLE_SHORT_HALVES = 7;
    localparam int SAMPLE_LONG_HALVES = 47;
    localparam int STARTUP_NS = 5000;
    localparam int CLK_PERIOD_NS = 8;
    localparam int STARTUP_CYCLES = STARTUP_NS / CLK_PERIOD_NS;
    localparam int ASYNC_DIV_DEFAULT = 63;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SYNC = 2'b01,
        ST_WARM = 2'b11,
        ST_CONV = 2'b10
    } state_e;

    typedef struct packed {
        logic conv_complete_flag;
        logic ien;
        logic cont;
        logic [4:0] ch;
    } scr_s;

    typedef struct packed {
        logic rsv7;
        logic [1:0] div;
        logic long_sample;
        logic mode10;
        logic rsv2;
        logic async_en;
        logic iclk;
    } clk_cfg_s;

    localparam scr_s SCR_RESET = '{conv_complete_flag: 1'b0, ien: 1'b0, cont: 1'b0, ch: CH_ALL_ONES};
    localparam clk_cfg_s CLK_RESET = '0;

    typedef struct packed {
        state_e st;
        scr_s scr;
        clk_cfg_s cfg;
        logic [9:0] res;
        logic hi_pend;
        logic irq;
        logic first;
        logic [5:0] cnt;
        logic [1:0] bcnt;
        logic [2:0] dcnt;
        logic [15:0] wcnt;
        logic [7:0] acnt;
        logic [1:0] alt_sy;
        logic alt_d;
        logic [1:0] stop_sy;
        logic [RAW_W-1:0] raw1;
        logic [RAW_W-1:0] raw2;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic power;
        logic sample;
    } seq_state_s;

    localparam seq_state_s SEQ_RESET = '{st: ST_IDLE, scr: SCR_RESET, cfg: CLK_RESET,
        res: RES_RESET, default: '0};

endpackage

// file: rtl/adc_conversion_sequencer.sv
// Local design decisions: the APB interface to the registers and the register addresses.
`timescale 1ns/1ns
// What this block does
// - Completion means result loaded, flag set together
// - Interrupt when flag sets with enable high
// - 10-bit split read blocks and discards result
// - Blocked transfer immediately starts another conversion
// - Control write aborts, restarts unless channel ones or stop held without async clock
// - Clock config write aborts conversion
// - Stop without async clock aborts conversion
// - Non-reset abort keeps last good result
// - Reset aborts and clears both result registers
// - Reset or abort enters low-power idle now, unless a control write restarts
// - 8-bit short: 18 CONVERTER_CLOCK+3 bus, then 16
// - 8-bit long: 38 CONVERTER_CLOCK+3 bus, then 36
// - 10-bit short: 21 CONVERTER_CLOCK+3 bus, then 19
// - 10-bit long: 41 CONVERTER_CLOCK+3 bus, then 39
// - Async clock adds up to 5 us start-up
// - Sample window 4 or 24 converter clocks
// - Result rounded to selected 8/10-bit width
// - Converter clock is input divided 1/2/4/8
// - With async clock off, bus clock chosen when select high, alt_clk_in edges low
// - 8-bit result goes to low register only
// - Continuous mode restarts after each completion
module adc_conversion_sequencer #(
    parameter int STARTUP = adc_seq_pkg::STARTUP_CYCLES,
    parameter int ASYNC_DIV = adc_seq_pkg::ASYNC_DIV_DEFAULT
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic alt_clk_in,
    input wire logic stop_req,
    input wire logic [adc_seq_pkg::RAW_W-1:0] raw_sample,
    output logic [4:0] channel_select_field,
    output logic analog_power_on,
    output logic sample_window,
    output logic conv_irq
);

    adc_seq_pkg::seq_state_s s;
    adc_seq_pkg::seq_state_s n;
    logic acc;
    logic wr_scr;
    logic wr_clk;
    logic rd_hi;
    logic rd_lo;
    logic xfer;
    logic blocked;
    logic abort;
    logic src_tick;
    logic converter_clock;
    logic [2:0] mask;
    logic [5:0] base;
    logic [5:0] total;
    logic [5:0] win;

    function automatic logic [9:0] round_result(input logic [10:0] r, input logic m10);
        logic [10:0] s10;
        logic [8:0] s8;
        s10 = {1'b0, r[10:1]} + {10'h000, r[0]};
        s8 = {1'b0, r[10:3]} + {8'h00, r[2]};
        if (m10) begin
            round_result = s10[10] ? 10'h3FF : s10[9:0];
        end else begin
            round_result = {2'b00, (s8[8] ? 8'hFF : s8[7:0])};
        end
    endfunction

    function automatic logic [5:0] conv_len(input logic m10, input logic lng);
        case ({m10, lng})
            2'b00: conv_len = 6'(adc_seq_pkg::CONV_CONVERTER_CLOCK_8_SHORT);
            2'b01: conv_len = 6'(adc_seq_pkg::CONV_CONVERTER_CLOCK_8_LONG);
            2'b10: conv_len = 6'(adc_seq_pkg::CONV_CONVERTER_CLOCK_10_SHORT);
            default: conv_len = 6'(adc_seq_pkg::CONV_CONVERTER_CLOCK_10_LONG);
        endcase
    endfunction

    always_comb begin
        n = s;
        // Two-flop synchronisers for pins from outside the clock domain
        n.alt_sy = {s.alt_sy[0], alt_clk_in};
        n.alt_d = s.alt_sy[1];
        n.stop_sy = {s.stop_sy[0], stop_req};
        n.raw1 = raw_sample;
        n.raw2 = s.raw1;

        // APB slave, one wait state
        acc = psel & penable & s.pready;
        wr_scr = acc & pwrite & (paddr == adc_seq_pkg::OFS_SCR);
        wr_clk = acc & pwrite & (paddr == adc_seq_pkg::OFS_CLK);
        rd_hi = acc & ~pwrite & (paddr == adc_seq_pkg::OFS_RES_HIGH);
        rd_lo = acc & ~pwrite & (paddr == adc_seq_pkg::OFS_RES_LOW);
        n.pready = psel & penable & ~s.pready;
        n.pslverr = 1'b0;
        if (n.pready) begin
            case (paddr)
                adc_seq_pkg::OFS_SCR: n.prdata = 32'(s.scr);
                adc_seq_pkg::OFS_RES_HIGH: n.prdata = 32'(s.res[9:8]);
                adc_seq_pkg::OFS_RES_LOW: n.prdata = 32'(s.res[7:0]);
                adc_seq_pkg::OFS_CLK: n.prdata = 32'(s.cfg);
                default: begin
                    n.prdata = '0;
                    n.pslverr = 1'b1;
                end
            endcase
        end

        // Async clock runs only while the converter is powered
        if (s.st == adc_seq_pkg::ST_IDLE || !s.cfg.async_en
                || s.acnt == 8'(ASYNC_DIV - 1)) begin
            n.acnt = '0;
        end else begin
            n.acnt = s.acnt + 8'd1;
        end
        if (s.cfg.async_en) begin
            src_tick = (s.st != adc_seq_pkg::ST_IDLE) && (s.acnt == 8'(ASYNC_DIV - 1));
        end else if (s.cfg.iclk) begin
            src_tick = 1'b1;
        end else begin
            src_tick = s.alt_sy[1] & ~s.alt_d;
        end
        case (s.cfg.div)
            2'd0: mask = 3'd0;
            2'd1: mask = 3'd1;
            2'd2: mask = 3'd3;
            default: mask = 3'd7;
        endcase
        converter_clock = src_tick && ((s.dcnt & mask) == mask);
        if (s.st != adc_seq_pkg::ST_CONV) begin
            n.dcnt = '0;
        end else if (src_tick) begin
            n.dcnt = s.dcnt + 3'd1;
        end

        // Cycle budgets per resolution and sample length
        base = s.first ? 6'(adc_seq_pkg::FIRST_EXTRA_CONVERTER_CLOCK) : 6'd0;
        total = base + conv_len(s.cfg.mode10, s.cfg.long_sample);

        xfer = 1'b0;
        blocked = 1'b0;
        case (s.st)
            adc_seq_pkg::ST_IDLE: begin
                n.cnt = '0;
            end
            adc_seq_pkg::ST_SYNC: begin
                if (s.bcnt == 2'(adc_seq_pkg::SYNC_BUS_CLKS - 1)) begin
                    n.bcnt = '0;
                    n.st = s.cfg.async_en ? adc_seq_pkg::ST_WARM : adc_seq_pkg::ST_CONV;
                end else begin
                    n.bcnt = s.bcnt + 2'd1;
                end
            end
            adc_seq_pkg::ST_WARM: begin
                if (s.wcnt == 16'(STARTUP - 1)) begin
                    n.wcnt = '0;
                    n.st = adc_seq_pkg::ST_CONV;
                end else begin
                    n.wcnt = s.wcnt + 16'd1;
                end
            end
            adc_seq_pkg::ST_CONV: begin
                if (converter_clock) begin
                    if (s.cnt == total - 6'd1) begin
                        n.cnt = '0;
                        n.first = 1'b0;
                        if (s.cfg.mode10 && s.hi_pend) begin
                            blocked = 1'b1;
                        end else begin
                            xfer = 1'b1;
                            n.res = round_result(s.raw2, s.cfg.mode10);
                            if (!s.scr.cont) begin
                                n.st = adc_seq_pkg::ST_IDLE;
                            end
                        end
                    end else begin
                        n.cnt = s.cnt + 6'd1;
                    end
                end
            end
            default: n.st = adc_seq_pkg::ST_IDLE;
        endcase

        // Flag and request: a completion beats a low-result read clear in the same cycle
        n.scr.conv_complete_flag = xfer | (s.scr.conv_complete_flag & ~(wr_scr | rd_lo));
        n.irq = (xfer & s.scr.ien) | (s.irq & n.scr.conv_complete_flag);
        if (rd_hi && s.cfg.mode10) begin
            n.hi_pend = 1'b1;
        end else if (rd_lo) begin
            n.hi_pend = 1'b0;
        end

        // Aborts leave the result untouched and drop to idle, unless a control write restarts
        abort = wr_scr | wr_clk | (s.stop_sy[1] & ~s.cfg.async_en);
        if (wr_clk) begin
            n.cfg = adc_seq_pkg::clk_cfg_s'(pwdata[7:0] & adc_seq_pkg::CLK_WR_MASK);
        end
        if (abort) begin
            n.st = adc_seq_pkg::ST_IDLE;
            n.res = s.res;
            n.scr.conv_complete_flag = 1'b0;
            n.irq = 1'b0;
        end
        if (wr_scr) begin
            n.scr.ien = pwdata[6];
            n.scr.cont = pwdata[5];
            n.scr.ch = pwdata[4:0];
            n.bcnt = '0;
            n.wcnt = '0;
            n.cnt = '0;
            n.first = 1'b1;
            if (pwdata[4:0] != adc_seq_pkg::CH_ALL_ONES && !(s.stop_sy[1] & ~s.cfg.async_en)) begin
                n.st = adc_seq_pkg::ST_SYNC;
            end
        end
        if (wr_clk) begin
            n.scr.conv_complete_flag = s.scr.conv_complete_flag;
            n.irq = s.irq;
        end

        // Window counted in whole converter clocks after the first-conversion lead-in
        win = n.cfg.long_sample ? 6'((adc_seq_pkg::SAMPLE_LONG_HALVES + 1) / 2)
                                : 6'((adc_seq_pkg::SAMPLE_SHORT_HALVES + 1) / 2);
        n.power = (n.st != adc_seq_pkg::ST_IDLE);
        n.sample = (n.st == adc_seq_pkg::ST_CONV)
            && (n.cnt >= (n.first ? 6'(adc_seq_pkg::FIRST_EXTRA_CONVERTER_CLOCK) : 6'd0))
            && (n.cnt < (n.first ? 6'(adc_seq_pkg::FIRST_EXTRA_CONVERTER_CLOCK) : 6'd0) + win);
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s <= adc_seq_pkg::SEQ_RESET;
        end else begin
            s <= n;
        end
    end

    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign channel_select_field = s.scr.ch;
    assign analog_power_on = s.power;
    assign sample_window = s.sample;
    assign conv_irq = s.irq;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    property p_conv_complete_flag_with_result;
        $rose(s.scr.conv_complete_flag) |-> $past(xfer) && s.res == $past(n.res);
    endproperty
    a_conv_complete_flag_with_result: assert property (p_conv_complete_flag_with_result) else $error("flag set without transfer");

    property p_irq_on_set;
        xfer && s.scr.ien && !abort |=> conv_irq && s.scr.conv_complete_flag;
    endproperty
    a_irq_on_set: assert property (p_irq_on_set) else $error("irq missing at completion");

    property p_blocked_discard;
        blocked && !abort |=> $stable(s.res) && !$rose(s.scr.conv_complete_flag);
    endproperty
    a_blocked_discard: assert property (p_blocked_discard) else $error("blocked result stored");

    property p_blocked_restart;
        blocked && !abort |=> s.st == adc_seq_pkg::ST_CONV && s.cnt == 6'd0 && analog_power_on;
    endproperty
    a_blocked_restart: assert property (p_blocked_restart) else $error("no restart after block");

    property p_scr_idle;
        wr_scr && pwdata[4:0] == adc_seq_pkg::CH_ALL_ONES |=> s.st == adc_seq_pkg::ST_IDLE ##1 !analog_power_on;
    endproperty
    a_scr_idle: assert property (p_scr_idle) else $error("all-ones channel started");

    property p_clk_abort;
        wr_clk |=> s.st == adc_seq_pkg::ST_IDLE && $stable(s.res);
    endproperty
    a_clk_abort: assert property (p_clk_abort) else $error("clock write did not abort");

    property p_stop_abort;
        s.stop_sy[1] && !s.cfg.async_en |=> s.st == adc_seq_pkg::ST_IDLE;
    endproperty
    a_stop_abort: assert property (p_stop_abort) else $error("stop did not abort");

    property p_abort_keeps;
        abort |=> $stable(s.res);
    endproperty
    a_abort_keeps: assert property (p_abort_keeps) else $error("abort changed result");

    property p_sync_three;
        s.st == adc_seq_pkg::ST_SYNC && $past(s.st) == adc_seq_pkg::ST_IDLE && !abort
            ##1 !abort[*2] |=> s.st != adc_seq_pkg::ST_SYNC;
    endproperty
    a_sync_three: assert property (p_sync_three) else $error("sync not 3 bus clocks");

    property p_len_8_short_next;
        xfer && !s.first && !s.cfg.mode10 && !s.cfg.long_sample |-> s.cnt == 6'd15;
    endproperty
    a_len_8_short_next: assert property (p_len_8_short_next) else $error("8-bit short length");

    property p_len_10_long_first;
        xfer && s.first && s.cfg.mode10 && s.cfg.long_sample |-> s.cnt == 6'd40;
    endproperty
    a_len_10_long_first: assert property (p_len_10_long_first) else $error("10-bit long length");

    property p_lo_read_unblocks;
        rd_lo |=> !s.hi_pend;
    endproperty
    a_lo_read_unblocks: assert property (p_lo_read_unblocks) else $error("pending kept");

    property p_hi_read_marks;
        rd_hi && s.cfg.mode10 |=> s.hi_pend;
    endproperty
    a_hi_read_marks: assert property (p_hi_read_marks) else $error("pending not set");

    property p_cont_restart;
        xfer && s.scr.cont && !abort |=> s.st == adc_seq_pkg::ST_CONV;
    endproperty
    a_cont_restart: assert property (p_cont_restart) else $error("no continuous restart");

    property p_scr_start;
        wr_scr && pwdata[4:0] != adc_seq_pkg::CH_ALL_ONES && !s.stop_sy[1]
            |=> s.st == adc_seq_pkg::ST_SYNC;
    endproperty
    a_scr_start: assert property (p_scr_start) else $error("control write did not start");

    property p_res_8bit_high;
        xfer && !s.cfg.mode10 && !abort |=> s.res[9:8] == 2'b00;
    endproperty
    a_res_8bit_high: assert property (p_res_8bit_high) else $error("8-bit result in high");

    property p_single_idle;
        xfer && !s.scr.cont && !abort |=> s.st == adc_seq_pkg::ST_IDLE && !analog_power_on;
    endproperty
    a_single_idle: assert property (p_single_idle) else $error("single did not power down");

    c_transfer: cover property (xfer);
    c_blocked: cover property (blocked);
    c_cont_second: cover property (xfer && !s.first && s.scr.cont);
    c_stop_abort: cover property (s.stop_sy[1] && s.st != adc_seq_pkg::ST_IDLE);

endmodule

// file: tb/adc_conversion_sequencer_tb.sv
`timescale 1ns/1ns
module adc_conversion_sequencer_tb;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic alt_clk_in = 1'b0;
    logic stop_req = 1'b0;
    logic [adc_seq_pkg::RAW_W-1:0] raw_sample = 11'h000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [4:0] channel_select_field;
    logic analog_power_on;
    logic sample_window;
    logic conv_irq;
    logic [31:0] rdv;
    logic errv;
    int bad_count = 0;
    int tests_run = 0;
    int cyc = 0;
    int sw_cnt = 0;
    int n;
    int t0;
    typedef struct {
        logic [7:0] cfg;
        logic [10:0] raw;
        logic [7:0] hi;
        logic [7:0] lo;
        int bud;
        int sw;
    } row_s;
    // Clock config, raw sample, result high/low, cycle budget, sample window
    row_s rows [9] = '{
        '{8'h01, 11'h2A5, 8'h00, 8'h55, 21, 4}, '{8'h11, 11'h0A3, 8'h00, 8'h14, 41, 24},
        '{8'h09, 11'h2A5, 8'h01, 8'h53, 24, 4}, '{8'h19, 11'h7FF, 8'h03, 8'hFF, 44, 24},
        '{8'h21, 11'h004, 8'h00, 8'h01, 39, 0}, '{8'h49, 11'h003, 8'h00, 8'h02, 87, 0},
        '{8'h61, 11'h7FF, 8'h00, 8'hFF, 147, 0}, '{8'h20, 11'h0A3, 8'h00, 8'h14, 75, 0},
        '{8'h02, 11'h2A5, 8'h00, 8'h55, 43, 0}};

    adc_conversion_sequencer #(.STARTUP(4), .ASYNC_DIV(2)) DUT (
        .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .alt_clk_in(alt_clk_in), .stop_req(stop_req),
        .raw_sample(raw_sample), .channel_select_field(channel_select_field),
        .analog_power_on(analog_power_on), .sample_window(sample_window),
        .conv_irq(conv_irq));

    always #4 mclk = ~mclk;
    always @(posedge mclk) begin
        alt_clk_in <= ~alt_clk_in;
        cyc <= cyc + 1;
        if (sample_window === 1'b1) begin
            sw_cnt <= sw_cnt + 1;
        end
    end

    task report_and_stop();
        $display("checks %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task chk_time(input int got, input int lo, input int hi);
        tests_run++;
        if (got < lo || got > hi) begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask

    // One APB transfer, held until pready, then one idle edge
    task apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
        int k;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h00_0000, d};
        @(posedge mclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge mclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (pready !== 1'b1) begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, pready, 1'b1);
        end
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask

    task rd_chk(input logic [7:0] a, input logic [7:0] exp);
        apb(1'b0, a, 8'h00);
        chk(rdv, {24'h00_0000, exp});
    endtask

    task wait_irq(input int lim);
        n = 0;
        while (conv_irq !== 1'b1 && n < lim) begin
            @(posedge mclk);
            n++;
        end
    endtask

    task end_test(input string name);
        $display("test %s done: %0d checks, %0d mismatches", name, tests_run, bad_count);
    endtask

    initial begin
        #200000;
        bad_count++;
        $display("[ERR] t=%0t got=%h exp=%h", $time, 32'h0000_0000, 32'h0000_0001);
        report_and_stop();
    end

    initial begin
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        rd_chk(adc_seq_pkg::OFS_SCR, 8'h1F);
        rd_chk(adc_seq_pkg::OFS_CLK, 8'h00);
        rd_chk(adc_seq_pkg::OFS_RES_HIGH, 8'h00);
        rd_chk(adc_seq_pkg::OFS_RES_LOW, 8'h00);
        apb(1'b0, 8'h10, 8'h00);
        chk({31'h0000_0000, errv}, 32'h0000_0001);
        chk(rdv, 32'h0000_0000);
        end_test("reset");
        foreach (rows[i]) begin
            raw_sample <= rows[i].raw;
            wr(adc_seq_pkg::OFS_CLK, rows[i].cfg);
            t0 = sw_cnt;
            wr(adc_seq_pkg::OFS_SCR, 8'h40);
            wait_irq(400);
            chk_time(n, rows[i].bud - rows[i].bud / 4, rows[i].bud + 4);
            if (rows[i].sw > 0) chk_time(sw_cnt - t0, rows[i].sw - 1, rows[i].sw);
            rd_chk(adc_seq_pkg::OFS_SCR, 8'hC0);
            rd_chk(adc_seq_pkg::OFS_RES_HIGH, rows[i].hi);
            rd_chk(adc_seq_pkg::OFS_RES_LOW, rows[i].lo);
            @(posedge mclk);
            chk({31'h0000_0000, conv_irq}, 32'h0000_0000);
            chk({31'h0000_0000, analog_power_on}, 32'h0000_0000);
            end_test("row");
        end
        raw_sample <= 11'h2A5;
        wr(adc_seq_pkg::OFS_CLK, 8'h09);
        wr(adc_seq_pkg::OFS_SCR, 8'h40);
        apb(1'b0, adc_seq_pkg::OFS_RES_HIGH, 8'h00);
        repeat (25) @(posedge mclk);
        chk({31'h0000_0000, conv_irq}, 32'h0000_0000);
        chk({31'h0000_0000, analog_power_on}, 32'h0000_0001);
        rd_chk(adc_seq_pkg::OFS_RES_LOW, 8'h55);
        wait_irq(30);
        chk_time(n, 1, 29);
        rd_chk(adc_seq_pkg::OFS_RES_HIGH, 8'h01);
        rd_chk(adc_seq_pkg::OFS_RES_LOW, 8'h53);
        end_test("blocked transfer");
        raw_sample <= 11'h100;
        wr(adc_seq_pkg::OFS_SCR, 8'h40);
        repeat (10) @(posedge mclk);
        wr(adc_seq_pkg::OFS_SCR, 8'h40);
        wait_irq(60);
        chk_time(n, 18, 28);
        rd_chk(adc_seq_pkg::OFS_RES_LOW, 8'h80);
        wr(adc_seq_pkg::OFS_SCR, 8'h40);
        repeat (8) @(posedge mclk);
        raw_sample <= 11'h3FE;
        wr(adc_seq_pkg::OFS_SCR, 8'h5F);
        @(posedge mclk);
        chk({31'h0000_0000, analog_power_on}, 32'h0000_0000);
        chk({27'h000_0000, channel_select_field}, 32'h0000_001F);
        repeat (40) @(posedge mclk);
        chk({31'h0000_0000, conv_irq}, 32'h0000_0000);
        rd_chk(adc_seq_pkg::OFS_RES_HIGH, 8'h00);
        rd_chk(adc_seq_pkg::OFS_RES_LOW, 8'h80);
        end_test("control write abort");
        wr(adc_seq_pkg::OFS_SCR, 8'h40);
        repeat (8) @(posedge mclk);
        wr(adc_seq_pkg::OFS_CLK, 8'h09);
        @(posedge mclk);
        chk({31'h0000_0000, analog_power_on}, 32'h0000_0000);
        repeat (40) @(posedge mclk);
        chk({31'h0000_0000, conv_irq}, 32'h0000_0000);
        wr(adc_seq_pkg::OFS_SCR, 8'h40);
        repeat (8) @(posedge mclk);
        stop_req <= 1'b1;
        repeat (5) @(posedge mclk);
        chk({31'h0000_0000, analog_power_on}, 32'h0000_0000);
        repeat (40) @(posedge mclk);
        chk({31'h0000_0000, conv_irq}, 32'h0000_0000);
        stop_req <= 1'b0;
        rd_chk(adc_seq_pkg::OFS_RES_LOW, 8'h80);
        end_test("clock and stop abort");
        raw_sample <= 11'h2A5;
        wr(adc_seq_pkg::OFS_CLK, 8'h01);
        wr(adc_seq_pkg::OFS_SCR, 8'h60);
        wait_irq(60);
        t0 = cyc;
        rd_chk(adc_seq_pkg::OFS_RES_LOW, 8'h55);
        wait_irq(40);
        chk_time(cyc - t0, 14, 18);
        wr(adc_seq_pkg::OFS_SCR, 8'h1F);
        @(posedge mclk);
        chk({31'h0000_0000, analog_power_on}, 32'h0000_0000);
        end_test("continuous");
        wr(adc_seq_pkg::OFS_SCR, 8'h00);
        repeat (40) @(posedge mclk);
        chk({31'h0000_0000, conv_irq}, 32'h0000_0000);
        rd_chk(adc_seq_pkg::OFS_SCR, 8'h80);
        rst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        chk({31'h0000_0000, analog_power_on}, 32'h0000_0000);
        rst_n <= 1'b1;
        @(posedge mclk);
        rd_chk(adc_seq_pkg::OFS_RES_LOW, 8'h00);
        rd_chk(adc_seq_pkg::OFS_SCR, 8'h1F);
        end_test("irq off and reset");
        report_and_stop();
    end
endmodule
